// ==== src/ptb_pkg.sv ====
// Shared constants and types of the PWM time-base register block.
// Assumes one 25 MHz core clock and a word-wide AHB-Lite slave port.
package ptb_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] PTB_OFS_PERIOD = 8'h00;
    localparam logic [7:0] PTB_OFS_PHASE = 8'h04;
    localparam logic [7:0] PTB_OFS_COUNTER = 8'h08;
    localparam logic [7:0] PTB_OFS_CONTROL = 8'h0C;

    // ************************************************************
    // Control field positions
    // ************************************************************
    localparam int PTB_POS_EMULATION = 14;
    localparam int PTB_POS_PHASE_DIR = 13;
    localparam int PTB_POS_CLK_PRESCALE = 10;
    localparam int PTB_POS_HS_PRESCALE = 7;
    localparam int PTB_POS_SW_SYNC = 6;
    localparam int PTB_POS_SYNC_OUT_SEL = 4;
    localparam int PTB_POS_PERIOD_DIRECT = 3;
    localparam int PTB_POS_PHASE_EN = 2;
    localparam int PTB_POS_COUNT_MODE = 0;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [15:0] PTB_RST_PERIOD = 16'h0000;
    localparam logic [15:0] PTB_RST_PHASE = 16'h0000;
    localparam logic [15:0] PTB_RST_COUNTER = 16'h0000;
    localparam logic [2:0] PTB_RST_HS_PRESCALE = 3'h1;
    localparam logic [1:0] PTB_RST_COUNT_MODE = 2'h3;
    localparam logic [15:0] PTB_RST_CONTROL =
        16'((PTB_RST_HS_PRESCALE << PTB_POS_HS_PRESCALE)
        | (PTB_RST_COUNT_MODE << PTB_POS_COUNT_MODE));

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {PTB_UP, PTB_DOWN, PTB_UPDOWN, PTB_STOP} ptb_mode_type;

    typedef enum logic [1:0] {PTB_SO_SYNC, PTB_SO_ZERO, PTB_SO_PERIOD, PTB_SO_OFF} ptb_so_type;

    typedef struct packed {
        logic [1:0] emulation;
        logic phase_direction;
        logic [2:0] clock_prescale;
        logic [2:0] high_speed_prescale;
        logic software_force_sync;
        ptb_so_type sync_output_select;
        logic period_load_direct;
        logic phase_load_enable;
        ptb_mode_type count_mode;
    } ptb_ctl_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } ptb_bus_req_type;

endpackage : ptb_pkg

// ==== src/ptb_prescaler.sv ====
// Time-base tick divider from the core clock.
// Assumes prescale codes come straight from the control register.
`timescale 1ns/10ps
module ptb_prescaler
    import ptb_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_run,
    input wire logic [2:0] i_hs_code,
    input wire logic [2:0] i_clk_code,
    output logic o_tick
);

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] last_w;
    logic [3:0] shift_w;

    // Divide is two to the power of both codes
    assign shift_w = {1'b0, i_hs_code} + {1'b0, i_clk_code};
    assign last_w = CNT_W'((32'h1 << shift_w) - 32'h1);

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            cnt_r <= '0;
        end
        else if (!i_run || cnt_r >= last_w)
        begin
            cnt_r <= '0;
        end
        else
        begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_tick <= 1'b0;
        end
        else
        begin
            o_tick <= i_run && cnt_r >= last_w;
        end
    end

endmodule : ptb_prescaler

// ==== src/ptb_ahb_port.sv ====
// AHB-Lite request capture for the time-base registers.
// Assumes zero wait states; only whole-word single transfers.
`timescale 1ns/10ps
module ptb_ahb_port
    import ptb_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output ptb_bus_req_type o_req
);

    logic addr_ph_w;
    logic wr_pend_r;
    logic [7:0] addr_r;

    assign addr_ph_w = i_hsel && i_htrans[1] && i_hready;

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            wr_pend_r <= 1'b0;
            addr_r <= 8'h00;
        end
        else
        begin
            wr_pend_r <= addr_ph_w && i_hwrite;
            if (addr_ph_w)
            begin
                addr_r <= i_haddr[7:0];
            end
        end
    end

    // Reads decode in address phase, writes in data phase
    always_comb
    begin
        o_req.wr = wr_pend_r;
        o_req.rd = addr_ph_w && !i_hwrite;
        o_req.addr = o_req.rd ? i_haddr[7:0] : addr_r;
        o_req.wdata = i_hwdata;
    end

endmodule : ptb_ahb_port

// ==== src/ptb_time_base.sv ====
// PWM time-base counter with its period, phase, counter and control registers.
// Assumes a single AHB-Lite master and a sync input synchronous to i_core_clk.
//
// How it works
// - 16-bit period sets counting cycle length
// - Shadow mode: access shadow, reload at zero
// - Direct mode: access active period immediately
// - Both period copies share one address
// - Period starts in shadowed mode after reset
// - Phase load disabled: sync ignored
// - Phase load enabled: sync copies phase
// - Sync from input pulse or software force
// - Phase is 16-bit offset to upstream
// - Counter read returns live count
// - Counter write takes effect immediately
// - Up-down: after sync count per direction
// - Tick is clock over both prescales
`timescale 1ns/10ps
module ptb_time_base
    import ptb_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic [2:0] i_hsize,
    input wire logic i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    input wire logic i_sync_input,
    output logic o_sync_out,
    output logic [15:0] o_counter_value,
    output logic o_count_up
);

    // ************************************************************
    // Registers
    // ************************************************************
    ptb_bus_req_type req_w;
    ptb_ctl_type ctl_r;
    logic [15:0] period_shadow_r;
    logic [15:0] period_active_r;
    logic [15:0] phase_offset_r;
    logic [15:0] ctr_r;
    logic dir_up_r;
    logic sw_sync_r;
    logic tick_w;
    logic sync_evt_w;
    logic run_w;
    logic wr_period_w;
    logic wr_phase_w;
    logic wr_ctr_w;
    logic wr_ctl_w;

    assign wr_period_w = req_w.wr && req_w.addr == PTB_OFS_PERIOD;
    assign wr_phase_w = req_w.wr && req_w.addr == PTB_OFS_PHASE;
    assign wr_ctr_w = req_w.wr && req_w.addr == PTB_OFS_COUNTER;
    assign wr_ctl_w = req_w.wr && req_w.addr == PTB_OFS_CONTROL;
    assign run_w = ctl_r.count_mode != PTB_STOP;
    assign sync_evt_w = i_sync_input || sw_sync_r;

    ptb_ahb_port u_port (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_hsel(i_hsel),
        .i_haddr(i_haddr),
        .i_htrans(i_htrans),
        .i_hwrite(i_hwrite),
        .i_hwdata(i_hwdata),
        .i_hready(i_hready),
        .o_req(req_w)
    );

    ptb_prescaler #(
        .CNT_W(16)
    ) u_prescaler (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_run(run_w),
        .i_hs_code(ctl_r.high_speed_prescale),
        .i_clk_code(ctl_r.clock_prescale),
        .o_tick(tick_w)
    );

    // ************************************************************
    // Control register
    // ************************************************************
    // reset values; shadowed after reset
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ctl_r <= ptb_ctl_type'(PTB_RST_CONTROL);
        end
        else if (wr_ctl_w)
        begin
            ctl_r <= ptb_ctl_type'(req_w.wdata[15:0]);
            ctl_r.software_force_sync <= 1'b0;
        end
    end

    // software force is a one-cycle sync
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sw_sync_r <= 1'b0;
        end
        else
        begin
            sw_sync_r <= wr_ctl_w && req_w.wdata[PTB_POS_SW_SYNC];
        end
    end

    // ************************************************************
    // Period and phase
    // ************************************************************
    // one address, copy chosen by load-direct bit
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            period_shadow_r <= PTB_RST_PERIOD;
        end
        else if (wr_period_w && !ctl_r.period_load_direct)
        begin
            period_shadow_r <= req_w.wdata[15:0];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            period_active_r <= PTB_RST_PERIOD;
        end
        else if (wr_period_w && ctl_r.period_load_direct)
        begin
            period_active_r <= req_w.wdata[15:0];
        end
        else if (!ctl_r.period_load_direct && ctr_r == 16'h0000)
        begin
            period_active_r <= period_shadow_r;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            phase_offset_r <= PTB_RST_PHASE;
        end
        else if (wr_phase_w)
        begin
            phase_offset_r <= req_w.wdata[15:0];
        end
    end

    // ************************************************************
    // Counter
    // ************************************************************
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ctr_r <= PTB_RST_COUNTER;
            dir_up_r <= 1'b1;
        end
        else if (wr_ctr_w)
        begin
            ctr_r <= req_w.wdata[15:0];
        end
        // phase load on sync only when enabled
        else if (sync_evt_w && ctl_r.phase_load_enable)
        begin
            ctr_r <= phase_offset_r;
            if (ctl_r.count_mode == PTB_UPDOWN)
            begin
                dir_up_r <= ctl_r.phase_direction;
            end
        end
        else if (tick_w)
        begin
            case (ctl_r.count_mode)
                PTB_UP:
                begin
                    dir_up_r <= 1'b1;
                    ctr_r <= (ctr_r >= period_active_r) ? 16'h0000 : ctr_r + 1'b1;
                end
                PTB_DOWN:
                begin
                    dir_up_r <= 1'b0;
                    ctr_r <= (ctr_r == 16'h0000) ? period_active_r : ctr_r - 1'b1;
                end
                PTB_UPDOWN:
                begin
                    if (period_active_r == 16'h0000)
                    begin
                        ctr_r <= 16'h0000;
                    end
                    else if (dir_up_r && ctr_r >= period_active_r)
                    begin
                        dir_up_r <= 1'b0;
                        ctr_r <= ctr_r - 1'b1;
                    end
                    else if (!dir_up_r && ctr_r == 16'h0000)
                    begin
                        dir_up_r <= 1'b1;
                        ctr_r <= ctr_r + 1'b1;
                    end
                    else
                    begin
                        ctr_r <= dir_up_r ? ctr_r + 1'b1 : ctr_r - 1'b1;
                    end
                end
                default:
                begin
                    ctr_r <= ctr_r;
                end
            endcase
        end
    end

    always_comb
    begin
        o_counter_value = ctr_r;
        o_count_up = dir_up_r;
    end

    // ************************************************************
    // Sync output
    // ************************************************************
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_sync_out <= 1'b0;
        end
        else
        begin
            case (ctl_r.sync_output_select)
                PTB_SO_SYNC: o_sync_out <= sync_evt_w;
                PTB_SO_ZERO: o_sync_out <= tick_w && ctr_r == 16'h0000;
                PTB_SO_PERIOD: o_sync_out <= tick_w && ctr_r == period_active_r;
                default: o_sync_out <= 1'b0;
            endcase
        end
    end

    // ************************************************************
    // Bus read and response
    // ************************************************************
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_hrdata <= 32'h0000_0000;
        end
        else if (req_w.rd)
        begin
            case (req_w.addr)
                PTB_OFS_PERIOD: o_hrdata <= {16'h0000, ctl_r.period_load_direct ?
                    period_active_r : period_shadow_r};
                PTB_OFS_PHASE: o_hrdata <= {16'h0000, phase_offset_r};
                PTB_OFS_COUNTER: o_hrdata <= {16'h0000, ctr_r};
                PTB_OFS_CONTROL: o_hrdata <= {16'h0000, 16'(ctl_r)};
                default: o_hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
        else
        begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);

    sequence s_sync_load;
        sync_evt_w && ctl_r.phase_load_enable && !wr_ctr_w;
    endsequence

    a_shadow_write: assert property (
        wr_period_w && !ctl_r.period_load_direct
        |=> period_shadow_r == $past(req_w.wdata[15:0]))
        else $error("shadow period not written");

    a_zero_reload: assert property (
        !ctl_r.period_load_direct && ctr_r == 16'h0000 && !wr_period_w
        |=> period_active_r == $past(period_shadow_r))
        else $error("active period not reloaded at zero");

    a_direct_write: assert property (
        wr_period_w && ctl_r.period_load_direct
        |=> period_active_r == $past(req_w.wdata[15:0])
        && $stable(period_shadow_r))
        else $error("direct period write misrouted");

    a_period_read: assert property (
        req_w.rd && req_w.addr == PTB_OFS_PERIOD && !ctl_r.period_load_direct
        |=> o_hrdata[15:0] == $past(period_shadow_r))
        else $error("period read not from shadow");

    a_sync_ignored: assert property (
        sync_evt_w && !ctl_r.phase_load_enable && !wr_ctr_w && !tick_w
        |=> $stable(ctr_r))
        else $error("counter moved on ignored sync");

    a_phase_load: assert property (
        s_sync_load |=> ctr_r == $past(phase_offset_r))
        else $error("phase not loaded on sync");

    a_sw_sync: assert property (
        wr_ctl_w && req_w.wdata[PTB_POS_SW_SYNC] && req_w.wdata[PTB_POS_PHASE_EN]
        ##1 !wr_ctr_w |=> ctr_r == $past(phase_offset_r))
        else $error("software sync did not load phase");

    a_counter_read: assert property (
        req_w.rd && req_w.addr == PTB_OFS_COUNTER
        |=> o_hrdata == {16'h0000, $past(ctr_r)})
        else $error("counter read not live");

    a_counter_write: assert property (
        wr_ctr_w |=> ctr_r == $past(req_w.wdata[15:0]))
        else $error("counter write not immediate");

    a_phase_dir: assert property (
        s_sync_load ##0 (ctl_r.count_mode == PTB_UPDOWN)
        |=> dir_up_r == $past(ctl_r.phase_direction))
        else $error("direction after sync wrong");

    a_tick_rate: assert property (
        tick_w && run_w && ctl_r.high_speed_prescale == 3'h1
        && ctl_r.clock_prescale == 3'h0 && !wr_ctl_w
        |=> !tick_w ##1 tick_w)
        else $error("tick spacing wrong for divide by two");

    a_stopped_idle: assert property (
        !run_w && !wr_ctr_w && !(sync_evt_w && ctl_r.phase_load_enable)
        |=> $stable(ctr_r))
        else $error("counter moved while stopped");

endmodule : ptb_time_base

// ==== bench/tb.sv ====
// Self-checking bench for the PWM time-base register block.
// Assumes the block answers AHB-Lite transfers with zero wait states.
`timescale 1ns/10ps
module tb;
    import ptb_pkg::*;

    // ************************************************************
    // Clock, reset and design ports
    // ************************************************************
    logic i_core_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic sync_in = 1'b0;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic sync_out;
    logic [15:0] cnt;
    logic cnt_up;
    int n_fail = 0;
    int checked = 0;
    logic [31:0] rd;
    logic [15:0] c0;
    int clk_code[7] = '{0, 1, 2, 3, 2, 0, 0};
    int hs_code[7] = '{0, 0, 0, 0, 1, 3, 1};
    int divs[7] = '{1, 2, 4, 8, 8, 8, 2};

    always #20 i_core_clk = ~i_core_clk;

    ptb_time_base DUT (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_hsel(hsel),
        .i_haddr(haddr),
        .i_htrans(htrans),
        .i_hsize(hsize),
        .i_hwrite(hwrite),
        .i_hwdata(hwdata),
        .i_hready(hready),
        .o_hreadyout(hready),
        .o_hresp(hresp),
        .o_hrdata(hrdata),
        .i_sync_input(sync_in),
        .o_sync_out(sync_out),
        .o_counter_value(cnt),
        .o_count_up(cnt_up)
    );

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge i_core_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        n = 0;
        do
        begin
            @(posedge i_core_clk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        n = 0;
        do
        begin
            @(posedge i_core_clk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        rd = hrdata;
        chk("response", 32'h0, {31'h0, hresp});
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        xfer(1'b1, a, {16'hFFFF, d});
    endtask : wr

    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask : rchk

    task automatic pulse_sync;
        @(posedge i_core_clk);
        sync_in <= 1'b1;
        @(posedge i_core_clk);
        sync_in <= 1'b0;
        #1;
        chk("sync out", 32'h1, {31'h0, sync_out});
        repeat (2) @(posedge i_core_clk);
        #1;
    endtask : pulse_sync

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    // ************************************************************
    // Watchdog
    // ************************************************************
    initial
    begin
        repeat (20000) @(posedge i_core_clk);
        n_fail++;
        $display("mismatch watchdog expected done seen hang");
        wrap_up();
    end

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial
    begin
        repeat (3) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        rchk("control", PTB_OFS_CONTROL, 32'h0083);
        rchk("period", PTB_OFS_PERIOD, 32'h0);
        rchk("phase", PTB_OFS_PHASE, 32'h0);
        rchk("counter", PTB_OFS_COUNTER, 32'h0);
        // Unmapped offset reads zero
        wr(8'h10, 16'hFFFF);
        rchk("unmapped", 8'h10, 32'h0);
        // full range held, upper bits read zero
        wr(PTB_OFS_PHASE, 16'hFFFF);
        rchk("phase", PTB_OFS_PHASE, 32'h0000FFFF);
        wr(PTB_OFS_COUNTER, 16'h0003);
        #1;
        chk("counter port", 32'h3, {16'h0, cnt});
        rchk("counter", PTB_OFS_COUNTER, 32'h3);
        // shadow and active on one offset
        wr(PTB_OFS_PERIOD, 16'hFFFF);
        rchk("shadow period", PTB_OFS_PERIOD, 32'hFFFF);
        wr(PTB_OFS_CONTROL, 16'h008B);
        rchk("active period", PTB_OFS_PERIOD, 32'h0);
        wr(PTB_OFS_PERIOD, 16'h0005);
        rchk("active period", PTB_OFS_PERIOD, 32'h5);
        wr(PTB_OFS_CONTROL, 16'h0083);
        rchk("shadow period", PTB_OFS_PERIOD, 32'hFFFF);
        wr(PTB_OFS_COUNTER, 16'h0000);
        wr(PTB_OFS_CONTROL, 16'h008B);
        rchk("reloaded period", PTB_OFS_PERIOD, 32'hFFFF);
        wr(PTB_OFS_PHASE, 16'h1234);
        wr(PTB_OFS_COUNTER, 16'h0007);
        wr(PTB_OFS_CONTROL, 16'h0083);
        pulse_sync();
        rchk("counter", PTB_OFS_COUNTER, 32'h7);
        wr(PTB_OFS_CONTROL, 16'h0087);
        pulse_sync();
        rchk("counter", PTB_OFS_COUNTER, 32'h1234);
        wr(PTB_OFS_COUNTER, 16'h0000);
        wr(PTB_OFS_CONTROL, 16'h00C7);
        repeat (2) @(posedge i_core_clk);
        rchk("counter", PTB_OFS_COUNTER, 32'h1234);
        rchk("control", PTB_OFS_CONTROL, 32'h0087);
        // direction after sync in up-down mode
        wr(PTB_OFS_PERIOD, 16'd100);
        wr(PTB_OFS_PHASE, 16'd50);
        wr(PTB_OFS_COUNTER, 16'd20);
        wr(PTB_OFS_CONTROL, 16'h000E);
        pulse_sync();
        chk("direction", 32'h0, {31'h0, cnt_up});
        chk("below phase", 32'h1, {31'h0, (cnt < 16'd50 && cnt > 16'd40)});
        wr(PTB_OFS_CONTROL, 16'h200E);
        pulse_sync();
        chk("direction", 32'h1, {31'h0, cnt_up});
        chk("above phase", 32'h1, {31'h0, (cnt > 16'd50 && cnt < 16'd60)});
        wr(PTB_OFS_CONTROL, 16'h000B);
        wr(PTB_OFS_PERIOD, 16'hFFFF);
        for (int i = 0; i < 7; i++)
        begin
            wr(PTB_OFS_COUNTER, 16'h0000);
            wr(PTB_OFS_CONTROL, 16'((clk_code[i] << 10) | (hs_code[i] << 7) | 8));
            repeat (3) @(posedge i_core_clk);
            #1;
            c0 = cnt;
            repeat (64) @(posedge i_core_clk);
            #1;
            chk("ticks", 32'(64 / divs[i]), {16'h0, cnt - c0});
            xfer(1'b0, PTB_OFS_COUNTER, 32'h0);
            #1;
            chk("live read", 32'h1, {31'h0, (rd[15:0] <= cnt && rd[15:0] + 16'd3 >= cnt)});
            wr(PTB_OFS_CONTROL, 16'h000B);
        end
        // down count reloads period, zero marked on sync out
        wr(PTB_OFS_PERIOD, 16'h0005);
        wr(PTB_OFS_COUNTER, 16'h0000);
        wr(PTB_OFS_CONTROL, 16'h0019);
        repeat (8) @(posedge i_core_clk);
        #1;
        chk("down count", 32'h5, {16'h0, cnt});
        chk("down direction", 32'h0, {31'h0, cnt_up});
        chk("zero sync out", 32'h1, {31'h0, sync_out});
        wrap_up();
    end
endmodule : tb
